// file: pwm_mode_pkg.sv
// constants shared by the pulse-width mode generator and its prescaler
//
// Overview of operation
// (RL1) pulse output pin, ten-bit duty resolution
// (RL2) software clears port B direction bit three; no direction bit is modelled here, the pin output is always driven
// (RL3) mode control zero forces pulse latch low
// (RL4) period is (period+1) times four times prescale
// (RL5) count equal to period clears next increment
// (RL6) pin set at period start unless zero duty
// (RL7) duty buffer copied to active at period start
// (RL8) postscaler never affects pulse frequency
// (RL9) high for duty time, low for rest
// (RL10) pin low when extended count reaches duty
package pwm_mode_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] OFS_MODE_CTRL = 4'h0;
   localparam logic [3:0] OFS_PERIOD = 4'h1;
   localparam logic [3:0] OFS_DUTY_BUF = 4'h2;
   localparam logic [3:0] OFS_TIMER_CTRL = 4'h3;
   localparam logic [3:0] OFS_TIMER_COUNT = 4'h4;
   localparam logic [3:0] OFS_DUTY_ACT_HI = 4'h5;
   localparam logic [3:0] OFS_DUTY_ACT_LO = 4'h6;
   localparam logic [3:0] OFS_STATUS = 4'h7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_MODE_CTRL = 8'h00;
   localparam logic [7:0] RST_PERIOD = 8'hFF;
   localparam logic [7:0] RST_DUTY_BUF = 8'h00;
   localparam logic [7:0] RST_TIMER_CTRL = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 4;
   localparam int DUTY_LOW_LSB = 4;
   localparam logic [1:0] MODE_PWM_TOP = 2'h3;
   localparam int TCTL_PRE_LSB = 0;
   localparam int TCTL_ON_BIT = 2;
   localparam int TCTL_POST_LSB = 3;
   localparam int STAT_POST_FLAG_BIT = 0;
   localparam int STAT_PIN_BIT = 1;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam int OSC_PER_INCR = 4;
   localparam logic [4:0] PRESCALE_1 = 5'h01;
   localparam logic [4:0] PRESCALE_4 = 5'h04;
   localparam logic [4:0] PRESCALE_16 = 5'h10;

endpackage

// file: tick_divider.sv
// prescaler: one-cycle tick every 1, 4 or 16 oscillator cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider
   import pwm_mode_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic run_in,
   input wire logic [1:0] ratio_sel_in,
   output logic tick_out
);

   typedef struct packed {
      logic [3:0] count;
   } div_state_type;

   div_state_type s_q;
   div_state_type s_d;
   logic [3:0] last;

   function automatic logic [3:0] ratio_last(input logic [1:0] sel);
      logic [4:0] r;
      r = (sel == 2'h0) ? PRESCALE_1 : (sel == 2'h1) ? PRESCALE_4 : PRESCALE_16;
      return 4'(r - 5'h01);
   endfunction

   assign last = ratio_last(ratio_sel_in);
   assign tick_out = run_in && (s_q.count >= last);

   always_comb begin
      s_d = s_q;
      if (!run_in) begin
         s_d.count = 4'h0;
      end else if (s_q.count >= last) begin
         s_d.count = 4'h0;
      end else begin
         s_d.count = s_q.count + 4'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule
`default_nettype wire

// file: pwm_mode_generator.sv
// pulse-width mode generator: period timer, duty compare, register port
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pwm_mode_generator
   import pwm_mode_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   output logic pulse_output_pin_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] unit_mode_control;
      logic [7:0] period_register;
      logic [7:0] duty_cycle_buffer;
      logic [7:0] timer_ctrl;
      logic [7:0] period_timer_count;
      logic [1:0] fine;
      logic [9:0] duty_cycle_active;
      logic [3:0] post_count;
      logic post_flag;
      logic pin;
      logic [7:0] rdata;
   } gen_state_type;

   gen_state_type s_q;
   gen_state_type s_d;

   logic quarter_tick;
   logic timer_on;
   logic pwm_mode;
   logic incr;
   logic boundary;
   logic [9:0] next_pos;
   logic [9:0] new_duty;
   logic post_set;

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
      return addr == ofs;
   endfunction

   assign timer_on = s_q.timer_ctrl[TCTL_ON_BIT];
   assign pwm_mode = s_q.unit_mode_control[MODE_LSB+MODE_W-1 -: 2] == MODE_PWM_TOP;
   assign incr = quarter_tick && (s_q.fine == 2'h3);
   assign boundary = incr && (s_q.period_timer_count == s_q.period_register);
   assign new_duty = {s_q.duty_cycle_buffer, s_q.unit_mode_control[DUTY_LOW_LSB +: 2]};
   assign post_set = boundary && (s_q.post_count == s_q.timer_ctrl[TCTL_POST_LSB +: 4]);

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   // (RL4) quarter ticks scale period
   tick_divider u_prescale (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .run_in(timer_on),
      .ratio_sel_in(s_q.timer_ctrl[TCTL_PRE_LSB +: 2]),
      .tick_out(quarter_tick)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      next_pos = {s_q.period_timer_count, s_q.fine};
      if (quarter_tick) begin
         // (RL4) four quarters per increment
         s_d.fine = s_q.fine + 2'h1;
         if (incr) begin
            if (boundary) begin
               // (RL5) match clears count
               s_d.period_timer_count = 8'h00;
            end else begin
               s_d.period_timer_count = s_q.period_timer_count + 8'h01;
            end
         end
         next_pos = {s_d.period_timer_count, s_d.fine};
         if (boundary) begin
            // (RL7) latch duty at start
            s_d.duty_cycle_active = new_duty;
            // (RL6) set unless zero duty
            s_d.pin = pwm_mode && (new_duty != 10'h000);
            // (RL8) postscaler only counts periods, pin untouched
            if (s_q.post_count == s_q.timer_ctrl[TCTL_POST_LSB +: 4]) begin
               s_d.post_count = 4'h0;
               s_d.post_flag = 1'b1;
            end else begin
               s_d.post_count = s_q.post_count + 4'h1;
            end
         end else if (next_pos == s_q.duty_cycle_active) begin
            // (RL9) low for the rest
            // (RL10) extended count reaches duty
            s_d.pin = 1'b0;
         end
      end
      // (RL3) latch low outside pulse mode
      if (!pwm_mode) begin
         s_d.pin = 1'b0;
      end
      // register writes
      if (reg_wr_in) begin
         if (reg_hit(reg_addr_in, OFS_MODE_CTRL)) begin
            s_d.unit_mode_control = reg_wdata_in;
            // (RL3) zero write clears latch
            if (reg_wdata_in == 8'h00) begin
               s_d.pin = 1'b0;
            end
         end else if (reg_hit(reg_addr_in, OFS_PERIOD)) begin
            s_d.period_register = reg_wdata_in;
         end else if (reg_hit(reg_addr_in, OFS_DUTY_BUF)) begin
            s_d.duty_cycle_buffer = reg_wdata_in;
         end else if (reg_hit(reg_addr_in, OFS_TIMER_CTRL)) begin
            s_d.timer_ctrl = reg_wdata_in;
         end else if (reg_hit(reg_addr_in, OFS_STATUS)) begin
            // set wins over clear in the same cycle
            if (reg_wdata_in[STAT_POST_FLAG_BIT] && !post_set) begin
               s_d.post_flag = 1'b0;
            end
         end
      end
      // read data stands one cycle only
      s_d.rdata = 8'h00;
      if (reg_rd_in) begin
         if (reg_hit(reg_addr_in, OFS_MODE_CTRL)) begin
            s_d.rdata = s_q.unit_mode_control;
         end else if (reg_hit(reg_addr_in, OFS_PERIOD)) begin
            s_d.rdata = s_q.period_register;
         end else if (reg_hit(reg_addr_in, OFS_DUTY_BUF)) begin
            s_d.rdata = s_q.duty_cycle_buffer;
         end else if (reg_hit(reg_addr_in, OFS_TIMER_CTRL)) begin
            s_d.rdata = s_q.timer_ctrl;
         end else if (reg_hit(reg_addr_in, OFS_TIMER_COUNT)) begin
            s_d.rdata = s_q.period_timer_count;
         end else if (reg_hit(reg_addr_in, OFS_DUTY_ACT_HI)) begin
            s_d.rdata = s_q.duty_cycle_active[9:2];
         end else if (reg_hit(reg_addr_in, OFS_DUTY_ACT_LO)) begin
            s_d.rdata = {6'h00, s_q.duty_cycle_active[1:0]};
         end else if (reg_hit(reg_addr_in, OFS_STATUS)) begin
            s_d.rdata = {6'h00, s_q.pin, s_q.post_flag};
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
         s_q.unit_mode_control <= RST_MODE_CTRL;
         s_q.period_register <= RST_PERIOD;
         s_q.duty_cycle_buffer <= RST_DUTY_BUF;
         s_q.timer_ctrl <= RST_TIMER_CTRL;
      end else begin
         s_q <= s_d;
      end
   end

   // (RL1) pin straight from latch
   assign pulse_output_pin_out = s_q.pin;
   assign reg_rdata_out = s_q.rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_MODE_OFF_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL3
      !pwm_mode |=> !s_q.pin)
      else $error("pulse latch high outside pulse mode");

   AST_ZERO_WRITE_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL3
      (reg_wr_in && reg_addr_in == OFS_MODE_CTRL && reg_wdata_in == 8'h00)
      |=> !s_q.pin ##1 !s_q.pin)
      else $error("zero mode write did not hold latch low");

   AST_TIMER_WRAP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL5
      boundary |=> s_q.period_timer_count == 8'h00 && s_q.fine == 2'h0)
      else $error("timer not cleared after period match");

   AST_TIMER_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL4
      (incr && !boundary) |=> s_q.period_timer_count == $past(s_q.period_timer_count) + 8'h01)
      else $error("timer did not step by one");

   AST_NO_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL4
      (!quarter_tick && !(reg_wr_in && reg_addr_in == OFS_TIMER_CTRL))
      |=> $stable(s_q.period_timer_count) && $stable(s_q.fine))
      else $error("timer moved without a prescaler tick");

   AST_PIN_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL6
      (boundary && pwm_mode && new_duty != 10'h000 && !reg_wr_in) |=> s_q.pin)
      else $error("pin not set at period start");

   AST_ZERO_DUTY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL6
      (boundary && new_duty == 10'h000) |=> !s_q.pin)
      else $error("pin set with zero duty");

   AST_DUTY_LATCH: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL7
      boundary |=> s_q.duty_cycle_active == $past(new_duty))
      else $error("active duty not loaded at period start");

   AST_DUTY_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL7
      !boundary |=> $stable(s_q.duty_cycle_active))
      else $error("active duty changed mid period");

   AST_FALL_AT_DUTY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL10
      ($fell(s_q.pin) && $past(pwm_mode) && !$past(reg_wr_in))
      |-> {s_q.period_timer_count, s_q.fine} == s_q.duty_cycle_active)
      else $error("pin fell away from duty position");

   AST_PIN_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      (!quarter_tick && pwm_mode && !reg_wr_in) |=> $stable(s_q.pin))
      else $error("pin changed without a timer tick");

   AST_READ_COUNT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL9
      (reg_rd_in && reg_addr_in == OFS_TIMER_COUNT)
      |=> reg_rdata_out == $past(s_q.period_timer_count)
      ##1 ($past(reg_rd_in) || reg_rdata_out == 8'h00))
      else $error("timer count readback wrong");

   AST_TICK_ONLY_ON: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL4
      !timer_on |-> !quarter_tick)
      else $error("prescaler ticked with timer off");

   AST_FINE_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL4
      quarter_tick |=> s_q.fine == $past(s_q.fine) + 2'h1)
      else $error("quarter phase did not advance");

   AST_PIN_LOW_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL9
      (!s_q.pin && !boundary) |=> !s_q.pin)
      else $error("pin rose away from period start");

   AST_PIN_HIGH_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL9
      (s_q.pin && pwm_mode && !reg_wr_in && !boundary
       && !(quarter_tick && next_pos == s_q.duty_cycle_active)) |=> s_q.pin)
      else $error("pin fell before duty position");

   // ----------------------------------------------------------------
   // register and status checks
   // ----------------------------------------------------------------
   AST_PERIOD_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL4
      (reg_wr_in && reg_addr_in == OFS_PERIOD)
      |=> s_q.period_register == $past(reg_wdata_in))
      else $error("period register write lost");

   AST_MODE_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL3
      (reg_wr_in && reg_addr_in == OFS_MODE_CTRL)
      |=> s_q.unit_mode_control == $past(reg_wdata_in))
      else $error("mode control write lost");

   AST_DUTY_BUF_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL7
      (reg_wr_in && reg_addr_in == OFS_DUTY_BUF)
      |=> s_q.duty_cycle_buffer == $past(reg_wdata_in))
      else $error("duty buffer write lost");

   AST_TCTL_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      (reg_wr_in && reg_addr_in == OFS_TIMER_CTRL)
      |=> s_q.timer_ctrl == $past(reg_wdata_in))
      else $error("timer control write lost");

   AST_DUTY_READ_HI: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL7
      (reg_rd_in && reg_addr_in == OFS_DUTY_ACT_HI)
      |=> {reg_rdata_out, 2'b00} == ($past(s_q.duty_cycle_active) & 10'h3FC))
      else $error("active duty high readback wrong");

   AST_DUTY_READ_LO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL7
      (reg_rd_in && reg_addr_in == OFS_DUTY_ACT_LO)
      |=> {2'b00, reg_rdata_out} == ($past(s_q.duty_cycle_active) & 10'h003))
      else $error("active duty low readback wrong");

   AST_STATUS_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL1
      (reg_rd_in && reg_addr_in == OFS_STATUS)
      |=> reg_rdata_out == {6'h00, $past(s_q.pin), $past(s_q.post_flag)})
      else $error("status readback wrong");

   AST_POST_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      post_set |=> s_q.post_flag)
      else $error("postscale flag not set");

   AST_POST_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      (reg_wr_in && reg_addr_in == OFS_STATUS
       && reg_wdata_in[STAT_POST_FLAG_BIT] && !post_set) |=> !s_q.post_flag)
      else $error("postscale flag not cleared");

   AST_POST_STICKY: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      (s_q.post_flag && !reg_wr_in) |=> s_q.post_flag)
      else $error("postscale flag dropped by itself");

   AST_POST_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      (!s_q.post_flag && !post_set) |=> !s_q.post_flag)
      else $error("postscale flag set off its count");

   AST_POST_COUNT_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RL8
      !boundary |=> $stable(s_q.post_count))
      else $error("postscale count moved mid period");

endmodule
`default_nettype wire

// file: pulse_load_model.sv
// behavioural load on the pulse pin: counts high cycles and rising edges in a window
`timescale 1ns/1ps
`default_nettype none
module pulse_load_model (
   input wire logic clk_sys_in,
   input wire logic pin_in,
   input wire logic window_in,
   output logic [15:0] high_count_out,
   output logic [15:0] rise_count_out
);
   logic last_q = 1'b0;
   always_ff @(posedge clk_sys_in) begin
      last_q <= pin_in;
      if (!window_in) begin
         high_count_out <= 16'h0000;
         rise_count_out <= 16'h0000;
      end else begin
         high_count_out <= high_count_out + {15'h0000, pin_in};
         rise_count_out <= rise_count_out + {15'h0000, pin_in & ~last_q};
      end
   end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the pulse-width mode generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pwm_mode_pkg::*;
   typedef struct {
      logic [1:0] pre; logic [7:0] per; logic [9:0] duty; logic [3:0] post;
      int t; logic [15:0] high; logic [15:0] rises;
   } row_type;
   // t is one period in clocks; high and rises are totals over two periods
   row_type rows [6] = '{
      '{2'h0, 8'h01, 10'h001, 4'h0, 8, 16'h0002, 16'h0002},
      '{2'h0, 8'h03, 10'h000, 4'h0, 16, 16'h0000, 16'h0000},
      '{2'h1, 8'h02, 10'h005, 4'h5, 48, 16'h0028, 16'h0002},
      '{2'h2, 8'h01, 10'h003, 4'h0, 128, 16'h0060, 16'h0002},
      '{2'h3, 8'h00, 10'h002, 4'hF, 64, 16'h0040, 16'h0002},
      '{2'h0, 8'h04, 10'h014, 4'h0, 20, 16'h0028, 16'h0000}};
   logic [7:0] rst_vals [4] = '{RST_MODE_CTRL, RST_PERIOD, RST_DUTY_BUF, RST_TIMER_CTRL};
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [ADDR_W-1:0] reg_addr_in = 4'h0;
   logic [DATA_W-1:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [DATA_W-1:0] reg_rdata_out;
   logic pulse_output_pin_out;
   logic window = 1'b0;
   logic [15:0] high_count;
   logic [15:0] rise_count;
   logic [7:0] d;
   int errors = 0;
   int n_compared = 0;

   always #5 clk_sys_in = ~clk_sys_in;

   pwm_mode_generator pwm_mode_generator_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .pulse_output_pin_out(pulse_output_pin_out));
   pulse_load_model pulse_load_model_i (.clk_sys_in(clk_sys_in),
      .pin_in(pulse_output_pin_out), .window_in(window),
      .high_count_out(high_count), .rise_count_out(rise_count));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= v;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      v = reg_rdata_out;
   endtask
   task automatic do_reset();
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      check({15'h0000, pulse_output_pin_out}, 16'h0000, "pin in reset");
      rst_b_in <= 1'b1;
   endtask
   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      final_report();
   end

   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      foreach (rows[i]) begin
         do_reset();
         wr(OFS_PERIOD, rows[i].per);
         wr(OFS_DUTY_BUF, rows[i].duty[9:2]);
         wr(OFS_MODE_CTRL, {2'b00, rows[i].duty[1:0], 4'hC});
         wr(OFS_TIMER_CTRL, {1'b0, rows[i].post, 1'b1, rows[i].pre});
         repeat (3 * rows[i].t) @(posedge clk_sys_in);
         window <= 1'b1;
         repeat (2 * rows[i].t) @(posedge clk_sys_in);
         window <= 1'b0;
         @(negedge clk_sys_in);
         check(high_count, rows[i].high, "high cycles");
         check(rise_count, rows[i].rises, "period starts");
         rd(OFS_DUTY_ACT_HI, d);
         check({8'h00, d}, {8'h00, rows[i].duty[9:2]}, "active duty high");
         rd(OFS_DUTY_ACT_LO, d);
         check({8'h00, d}, {14'h0000, rows[i].duty[1:0]}, "active duty low");
         $display("row %0d done", i);
      end
      do_reset();
      for (int k = 0; k < 4; k++) begin
         rd(k[3:0], d);
         check({8'h00, d}, {8'h00, rst_vals[k]}, "reset value");
      end
      rd(OFS_TIMER_COUNT, d);
      check({8'h00, d}, 16'h0000, "count after reset");
      wr(OFS_DUTY_ACT_HI, 8'hAA);
      rd(OFS_DUTY_ACT_HI, d);
      check({8'h00, d}, 16'h0000, "read-only write");
      rd(4'hC, d);
      check({8'h00, d}, 16'h0000, "unmapped read");
      $display("register test done");
      // period 1024 clocks, duty 512 quarters
      wr(OFS_DUTY_BUF, 8'h80);
      wr(OFS_MODE_CTRL, 8'h0C);
      wr(OFS_TIMER_CTRL, 8'h04);
      for (int k = 0; k < 3000 && pulse_output_pin_out !== 1'b1; k++) @(negedge clk_sys_in);
      @(negedge clk_sys_in);
      check({15'h0000, pulse_output_pin_out}, 16'h0001, "pin set at start");
      wr(OFS_DUTY_BUF, 8'h10);
      rd(OFS_DUTY_ACT_HI, d);
      check({8'h00, d}, 16'h0080, "duty held mid-period");
      check({15'h0000, pulse_output_pin_out}, 16'h0001, "pin still high");
      rd(OFS_STATUS, d);
      check({8'h00, d}, 16'h0003, "status pin and flag");
      rd(OFS_TIMER_COUNT, d);
      check({15'h0000, d < 8'h80}, 16'h0001, "count inside high time");
      wr(OFS_MODE_CTRL, 8'h00);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check({15'h0000, pulse_output_pin_out}, 16'h0000, "mode clear forces low");
      wr(OFS_TIMER_CTRL, 8'h00);
      wr(OFS_STATUS, 8'h01);
      rd(OFS_STATUS, d);
      check({8'h00, d}, 16'h0000, "flag cleared");
      $display("mid-period test done");
      final_report();
   end
endmodule
`default_nettype wire
